// *** design/nvac_map.vh ***
`ifndef NVAC_MAP_VH
`define NVAC_MAP_VH
`define NVAC_ADDR_CONTROL 12'hfa6
`define NVAC_ADDR_UNLOCK 12'hfa7
`define NVAC_ADDR_VALUE 12'hfa8
`define NVAC_ADDR_INDEX 12'hfa9
`define NVAC_BIT_SELECT 7
`define NVAC_BIT_ROWERASE 4
`define NVAC_BIT_ABORT 3
`define NVAC_BIT_PERMIT 2
`define NVAC_BIT_WRSTART 1
`define NVAC_BIT_RDSTART 0
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'haa
`define NVAC_ZERO_BYTE 8'h00
`define NVAC_WRITE_CYCLES 16'd4000
`define NVAC_PWRT_CYCLES 24'd2880000
`endif

// *** design/nvac_store.v ***
`timescale 1ns/1ps
`default_nettype none
module nvac_store #(
	parameter DEPTH = 64,
	parameter AW = 6
) (
	input wire clk,
	input wire store_permit_bit,
	input wire [AW-1:0] wrAddr,
	input wire [7:0] wrData,
	input wire [AW-1:0] rdAddr,
	output reg [7:0] rdData
);
	reg [7:0] mem [0:DEPTH-1];
	always @(posedge clk) begin
		if (store_permit_bit) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

// *** design/nvac_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "nvac_map.vh"
module nvac_top #(
	parameter DEPTH = 64,
	parameter AW = 6,
	parameter [15:0] WRITE_CYCLES = `NVAC_WRITE_CYCLES,
	parameter [23:0] PWRT_CYCLES = `NVAC_PWRT_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire porReset,
	input wire warmReset,
	input wire sfrWr,
	input wire sfrRd,
	input wire [11:0] sfrAddr,
	input wire [7:0] sfrWdata,
	input wire doneFlagClr,
	input wire codeProtect,
	output reg [7:0] sfrRdata,
	output reg nvDoneFlag,
	output reg flashEraseReq,
	output reg flashWriteReq,
	output reg [7:0] flashByte
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WRITE = 2'd1;
	localparam ST_DONE = 2'd2;

	function hit;
		input [11:0] a;
		input [11:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	reg [7:0] byteValue_r;
	reg [7:0] byteIndex_r;
	reg selectBit_r;
	reg rowErase_r;
	reg abortFlag_r;
	reg permitBit_r;
	reg wrStart_r;
	reg rdStart_r;
	reg [1:0] unlockStage_r;
	reg [1:0] state_r;
	reg [15:0] timer_r;
	reg [23:0] pwrt_r;
	reg pwrtDone_r;
	reg writeIsErase_r;
	wire [7:0] storeData;
	wire [7:0] controlByte;
	wire ctlWrite;
	wire wantStart;
	wire storeWrite;

	// code protect does not gate core access
	assign ctlWrite = sfrWr && hit(sfrAddr, `NVAC_ADDR_CONTROL);
	assign controlByte = {selectBit_r, 2'b00, rowErase_r, abortFlag_r,
		permitBit_r, wrStart_r, rdStart_r};
	// start needs key, earlier permit, idle, timer expired
	assign wantStart = ctlWrite && sfrWdata[`NVAC_BIT_WRSTART] &&
		(unlockStage_r == 2'd2) && permitBit_r && pwrtDone_r &&
		!wrStart_r;
	assign storeWrite = (state_r == ST_WRITE) && (timer_r == 16'h0001) &&
		!writeIsErase_r && !selectBit_r;

	// data array; one write stores new byte over the old one, erase leaves it unchanged
	nvac_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
		.clk(clk),
		.store_permit_bit(storeWrite),
		.wrAddr(byteIndex_r[AW-1:0]),
		.wrData(byteValue_r),
		.rdAddr(byteIndex_r[AW-1:0]),
		.rdData(storeData)
	);

	// power-up timer, only rst and power-on reset restart it
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pwrt_r <= 24'h000000;
			pwrtDone_r <= 1'b0;
		end else if (porReset) begin
			pwrt_r <= 24'h000000;
			pwrtDone_r <= 1'b0;
		end else if (!pwrtDone_r) begin
			pwrt_r <= pwrt_r + 24'h000001;
			pwrtDone_r <= (pwrt_r + 24'h000001 >= PWRT_CYCLES);
		end
	end

	// retained registers: index, value, select
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			byteIndex_r <= 8'h00;
			byteValue_r <= 8'h00;
			selectBit_r <= 1'b0;
		end else if (porReset) begin
			byteIndex_r <= 8'h00;
			byteValue_r <= 8'h00;
			selectBit_r <= 1'b0;
		end else if (!warmReset) begin
			if (sfrWr && hit(sfrAddr, `NVAC_ADDR_INDEX)) begin
				byteIndex_r <= sfrWdata;
			end
			if (sfrWr && hit(sfrAddr, `NVAC_ADDR_VALUE)) begin
				byteValue_r <= sfrWdata;
			end
			if (ctlWrite) begin
				selectBit_r <= sfrWdata[`NVAC_BIT_SELECT];
			end
			if (rdStart_r) begin
				byteValue_r <= storeData;
			end
		end
	end

	// control bits, unlock sequencer and write timer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rowErase_r <= 1'b0;
			abortFlag_r <= 1'b0;
			permitBit_r <= 1'b0;
			wrStart_r <= 1'b0;
			rdStart_r <= 1'b0;
			unlockStage_r <= 2'd0;
			state_r <= ST_IDLE;
			timer_r <= 16'h0000;
			writeIsErase_r <= 1'b0;
			nvDoneFlag <= 1'b0;
			flashEraseReq <= 1'b0;
			flashWriteReq <= 1'b0;
			flashByte <= 8'h00;
		end else if (porReset || warmReset) begin
			// an aborted write leaves the abort flag set
			if (warmReset && state_r == ST_WRITE) begin
				abortFlag_r <= 1'b1;
			end else if (porReset) begin
				abortFlag_r <= 1'b0;
			end
			rowErase_r <= 1'b0;
			permitBit_r <= 1'b0;
			wrStart_r <= 1'b0;
			rdStart_r <= 1'b0;
			unlockStage_r <= 2'd0;
			state_r <= ST_IDLE;
			timer_r <= 16'h0000;
			writeIsErase_r <= 1'b0;
			flashEraseReq <= 1'b0;
			flashWriteReq <= 1'b0;
			if (porReset) begin
				nvDoneFlag <= 1'b0;
			end
		end else begin
			flashEraseReq <= 1'b0;
			flashWriteReq <= 1'b0;
			// read start is set-only and self-clears
			rdStart_r <= ctlWrite && sfrWdata[`NVAC_BIT_RDSTART] &&
				!selectBit_r && !sfrWdata[`NVAC_BIT_SELECT];
			// unlock port holds no data, only sequence stage
			if (sfrWr && hit(sfrAddr, `NVAC_ADDR_UNLOCK)) begin
				if (sfrWdata == `NVAC_KEY_FIRST) begin
					unlockStage_r <= 2'd1;
				end else if (sfrWdata == `NVAC_KEY_SECOND &&
					unlockStage_r == 2'd1) begin
					unlockStage_r <= 2'd2;
				end else begin
					unlockStage_r <= 2'd0;
				end
			end else if (sfrWr) begin
				unlockStage_r <= 2'd0;
			end
			if (ctlWrite) begin
				permitBit_r <= sfrWdata[`NVAC_BIT_PERMIT];
				abortFlag_r <= sfrWdata[`NVAC_BIT_ABORT];
				if (state_r == ST_IDLE) begin
					rowErase_r <= sfrWdata[`NVAC_BIT_ROWERASE];
				end
			end
			// done flag: set wins over clear
			if (doneFlagClr) begin
				nvDoneFlag <= 1'b0;
			end
			case (state_r)
				ST_IDLE: begin
					if (wantStart) begin
						wrStart_r <= 1'b1;
						writeIsErase_r <= rowErase_r;
						timer_r <= WRITE_CYCLES;
						state_r <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					timer_r <= timer_r - 16'h0001;
					if (timer_r == 16'h0001) begin
						state_r <= ST_DONE;
						flashEraseReq <= selectBit_r && writeIsErase_r;
						flashWriteReq <= selectBit_r && !writeIsErase_r;
						flashByte <= byteValue_r;
					end
				end
				ST_DONE: begin
					wrStart_r <= 1'b0;
					if (writeIsErase_r) begin
						rowErase_r <= 1'b0;
					end
					abortFlag_r <= 1'b0;
					nvDoneFlag <= 1'b1;
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// read mux; unlock port reads zero
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sfrRdata <= 8'h00;
		end else if (sfrRd && hit(sfrAddr, `NVAC_ADDR_CONTROL)) begin
			sfrRdata <= controlByte;
		end else if (sfrRd && hit(sfrAddr, `NVAC_ADDR_VALUE)) begin
			sfrRdata <= byteValue_r;
		end else if (sfrRd && hit(sfrAddr, `NVAC_ADDR_INDEX)) begin
			sfrRdata <= byteIndex_r;
		end else begin
			sfrRdata <= `NVAC_ZERO_BYTE;
		end
	end
endmodule
`default_nettype wire

// *** dv/nvac_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvac_top_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic porReset,
	input wire logic warmReset,
	input wire logic sfrWr,
	input wire logic sfrRd,
	input wire logic [11:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic doneFlagClr,
	input wire logic [7:0] sfrRdata,
	input wire logic nvDoneFlag,
	input wire logic flashEraseReq,
	input wire logic flashWriteReq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_unlock_zero: assert property (
		sfrRd && sfrAddr == 12'hfa7 |=> sfrRdata == 8'h00) else $error("unlock");
	a_ctrl_gap: assert property (
		sfrRd && sfrAddr == 12'hfa6 |=> sfrRdata[6:5] == 2'b00) else $error("gap");
	a_index_byte: assert property (
		sfrWr && sfrAddr == 12'hfa9 && !porReset && !warmReset ##1
		!porReset && !(sfrWr && sfrAddr == 12'hfa9) ##1
		sfrRd && sfrAddr == 12'hfa9 && !porReset
		|=> sfrRdata == $past(sfrWdata, 3)) else $error("index");
	a_done_swclr: assert property (
		$fell(nvDoneFlag) |-> $past(doneFlagClr) || $past(porReset))
		else $error("done");
	a_erase_pulse: assert property (
		flashEraseReq |=> !flashEraseReq) else $error("erase");
	a_write_pulse: assert property (
		flashWriteReq |=> !flashWriteReq) else $error("write");
	a_erase_only: assert property (
		!(flashEraseReq && flashWriteReq)) else $error("both");
	a_pwrt_quiet: assert property (
		porReset |=> !nvDoneFlag [*8]) else $error("pwrt");
endmodule
bind nvac_top nvac_top_asserts chk_u (.*);
`default_nettype wire

// *** dv/nvac_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvac_core_model (
	input wire logic clk,
	output logic sfrWr = 0,
	output logic sfrRd = 0,
	output logic [11:0] sfrAddr = 0,
	output logic [7:0] sfrWdata = 0,
	output logic doneFlagClr = 0
);
	task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 {sfrWr, sfrRd, sfrAddr, sfrWdata} = {w, !w, a, d};
		@(posedge clk);
		#1 {sfrWr, sfrRd, sfrAddr, sfrWdata} = {2'b00, ~a, ~d};
	endtask
	// store with chosen second key and control base
	task store(input logic [5:0] i, input logic [7:0] v, k, c);
		acc(1, 12'hfa9, {2'b00, i});
		acc(1, 12'hfa8, v);
		acc(1, 12'hfa6, c);
		acc(1, 12'hfa7, 8'h55);
		acc(1, 12'hfa7, k);
		acc(1, 12'hfa6, c | 8'h02);
	endtask
	task clr;
		@(posedge clk);
		#1 doneFlagClr = 1;
		@(posedge clk);
		#1 doneFlagClr = 0;
	endtask
endmodule
`default_nettype wire

// *** dv/test_data_eeprom_access_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_access_control;
	logic clk, rst, porReset, warmReset, codeProtect;
	logic sfrWr, sfrRd, doneFlagClr, nvDoneFlag;
	logic flashEraseReq, flashWriteReq;
	logic rdPend = 0;
	logic [11:0] sfrAddr;
	logic [7:0] sfrWdata, sfrRdata, flashByte, v;
	logic [5:0] i;
	logic [9:0] rdQ[$], flQ[$];
	int mismatches = 0, check_count = 0;
	nvac_top #(.WRITE_CYCLES(16'd8), .PWRT_CYCLES(24'd40)) dut_u (.*);
	nvac_core_model core_u (.*);
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task cmp(input logic [9:0] g, e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	always @(posedge clk) begin
		rdPend <= sfrRd;
		if (rdPend) cmp({2'b00, sfrRdata}, rdQ.pop_front());
		if (flashEraseReq | flashWriteReq)
			cmp({flashEraseReq, flashWriteReq, flashByte}, flQ.pop_front());
	end
	task rd(input logic [11:0] a, input logic [7:0] e);
		rdQ.push_back({2'b00, e});
		core_u.acc(0, a, 8'h00);
	endtask
	task waitd;
		for (int n = 0; n < 30 && !(nvDoneFlag | flashEraseReq | flashWriteReq); n++)
			@(posedge clk);
	endtask
	task finish_test;
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h5ea98ae3));
		{rst, porReset, warmReset, codeProtect} = 4'b1001;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		core_u.store(6'h01, 8'h5a, 8'haa, 8'h04);
		waitd();
		cmp({9'h0, nvDoneFlag}, 10'h000);
		repeat (40) @(posedge clk);
		for (int n = 0; n < 6; n++) begin
			i = n < 2 ? {6{n[0]}} : 6'($urandom);
			v = 8'($urandom);
			core_u.store(i, v, 8'haa, 8'h04);
			waitd();
			cmp({9'h0, nvDoneFlag}, 10'h001);
			core_u.clr();
			core_u.acc(1, 12'hfa8, ~v);
			core_u.acc(1, 12'hfa6, 8'h05);
			rd(12'hfa8, v);
			rd(12'hfa9, {2'b00, i});
			rd(12'hfa7, 8'h00);
			rd(12'hfa6, 8'h04);
		end
		core_u.store(i, ~v, 8'h5a, 8'h04);
		waitd();
		cmp({9'h0, nvDoneFlag}, 10'h000);
		core_u.store(i, v, 8'haa, 8'h04);
		repeat (3) @(posedge clk);
		#1 warmReset = 1;
		@(posedge clk);
		#1 warmReset = 0;
		rd(12'hfa6, 8'h08);
		rd(12'hfa8, v);
		rd(12'hfa9, {2'b00, i});
		flQ.push_back({2'b10, v});
		core_u.store(i, v, 8'haa, 8'h94);
		waitd();
		core_u.clr();
		rd(12'hfa6, 8'h84);
		flQ.push_back({2'b01, ~v});
		core_u.store(i, ~v, 8'haa, 8'h84);
		waitd();
		core_u.clr();
		core_u.acc(1, 12'hfa9, 8'hc5);
		rd(12'hfa9, 8'hc5);
		#1 porReset = 1;
		@(posedge clk);
		#1 porReset = 0;
		rd(12'hfa6, 8'h00);
		repeat (2) @(posedge clk);
		cmp(10'(flQ.size()), 10'h000);
		finish_test();
	end
	initial begin
		repeat (4000) @(posedge clk);
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
